// ### src/crs_pkg.sv
// Package of constants and carrier types for the chip reset sequencer
package crs_pkg;

  // Clock rate
  localparam int unsigned CLK_HZ          = 50_000_000;
  localparam int unsigned CLK_PERIOD_PS   = 20_000;

  // Power-on release delay after the reset pin rises, in nanoseconds (typ figure)
  localparam int unsigned POR_HOLD_MIN_NS = 2200;
  localparam int unsigned POR_HOLD_TYP_NS = 3000;
  localparam int unsigned POR_HOLD_MAX_NS = 4200;
  localparam int unsigned POR_HOLD_CYC    =
    (POR_HOLD_TYP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // Debounce of the merged reset source, in clocks
  localparam int unsigned DEBOUNCE_CYC    = 100;

  // Boot copy phase, in microseconds
  localparam int unsigned BOOT_MIN_US     = 4100;
  localparam int unsigned BOOT_MAX_US     = 4900;
  localparam int unsigned BOOT_MIN_CYC    = (BOOT_MIN_US * (CLK_HZ / 1_000_000));

  // Boot image size in bytes
  localparam int unsigned BOOT_BYTES      = 16384;

  // Power-on flash reset pulse length, in clocks
  localparam int unsigned FLASH_PULSE_CYC = 16;

  // Sequencer states, one-hot
  typedef enum logic [4:0] {
    CRS_POR  = 5'h01,
    CRS_DBNC = 5'h02,
    CRS_BOOT = 5'h04,
    CRS_WAIT = 5'h08,
    CRS_RUN  = 5'h10
  } crs_state_t;

  // Reset stage outputs, all active low
  typedef struct packed {
    logic por_n;
    logic reset_source_n;
    logic boot_loader_rst_n;
    logic system_rst_n;
  } crs_stage_t;

  // Boot copy handshake toward flash and program SRAM
  typedef struct packed {
    logic        start;
    logic [13:0] addr;
  } crs_copy_t;

endpackage

// ### src/crs_sync.sv
// Three-stage pin synchroniser with agreement of the last two stages
`timescale 1ns/100ps
module crs_sync (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic pin_in,
  output logic      level_out
);
  import crs_pkg::*;

  logic [2:0] sync_r;
  logic [2:0] sync_nxt;
  logic       level_r;
  logic       level_nxt;

  // Shift in; level changes only when stages two and three agree
  always_comb begin
    sync_nxt  = {sync_r[1:0], pin_in};
    level_nxt = (sync_r[1] == sync_r[2]) ? sync_r[2] : level_r;
  end

  // Resets to asserted (low) so the chip starts held
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sync_r  <= 3'h0;
      level_r <= 1'b0;
    end else begin
      sync_r  <= sync_nxt;
      level_r <= level_nxt;
    end
  end

  assign level_out = level_r;

endmodule // crs_sync

// ### src/crs_top.sv
// Chip reset sequencer: merges reset sources and releases stages in order
`timescale 1ns/100ps

// Operation
// RQ1 - Any source asserts the system reset
// RQ2 - Power-on pulse resets the flash
// RQ3 - Power-on reset held about 3 us
// RQ4 - Debounced source released 100 clocks later
// RQ5 - System reset held during boot copy
// RQ6 - Boot copy on hardware reset and reboot
// RQ7 - Stages release in order, restart on source
module crs_top #(
  parameter int unsigned BOOT_CYC = crs_pkg::BOOT_MIN_CYC
) (
  input  wire logic          core_clk,
  input  wire logic          rst,
  input  wire logic          ext_rst_n,
  input  wire logic          power_on,
  input  wire logic          software_reboot_request,
  input  wire logic          copy_done,
  output crs_pkg::crs_stage_t stage,
  output crs_pkg::crs_copy_t  copy,
  output logic               flash_rst
);
  import crs_pkg::*;

  // Sequence walk, one step per state:
  //   POR  - all stages low; counts the power-on hold once no source is active
  //   DBNC - power-on stage released; counts the debounce span of the source
  //   BOOT - source stage released; one cycle to launch the boot copy
  //   WAIT - boot loader out of reset; copy runs while system reset stays low
  //   RUN  - every stage released; only a new source assertion leaves it
  // Any source seen at an edge forces POR at that same edge, so even a short
  // source pulse restarts the whole walk from the first stage.
  // The pin path adds about four clocks before the hold starts; the hold is
  // counted from the typical figure so that latency keeps it inside limits.
  // The boot phase ends only when the copy engine reports done and the
  // minimum phase time has run out; a slow copy stretches the phase, a fast
  // one never shortens it.
  // Limitation: no upper bound is enforced on the boot phase; a copy engine
  // that never reports done leaves system reset asserted for good.
  // One counter serves all timed states and starts from zero in each of them,
  // so its width is set by the longest span, the boot phase at full rate.

  // Counter width covers the full boot phase at the nominal clock
  localparam int unsigned CW = 18;

  // Synchronised pin level, low while the pin holds the chip in reset
  logic       pin_n;

  // Sequencer state and its shared span counter
  crs_state_t state_r;
  crs_state_t state_nxt;
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;

  // Stage levels and boot copy launch
  crs_stage_t stage_r;
  crs_stage_t stage_nxt;
  crs_copy_t  copy_r;
  crs_copy_t  copy_nxt;

  // Flash reset pulse and its power-on edge memory
  logic       flash_r;
  logic       flash_nxt;
  logic [4:0] fcnt_r;
  logic [4:0] fcnt_nxt;
  logic       pwr_seen_r;
  logic       pwr_seen_nxt;

  // Merged reset source
  logic       src_active;

  // Terminal count test shared by the power-on and debounce holds
  function automatic logic cnt_done(input logic [CW-1:0] cnt, input int unsigned len);
    cnt_done = (cnt >= CW'(len - 1));
  endfunction

  // Reset pin arrives from outside the clock domain
  crs_sync u_pin_sync (
    .core_clk  (core_clk),
    .rst       (rst),
    .pin_in    (ext_rst_n),
    .level_out (pin_n)
  );

  // Any of the three sources restarts the whole stage sequence
  assign src_active = ~pin_n | power_on | software_reboot_request; // RQ1

  // Sequencer next state and stage levels
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    stage_nxt = stage_r;
    copy_nxt  = copy_r;
    copy_nxt.start = 1'b0;
    if (src_active) begin
      state_nxt = CRS_POR; // RQ7
      cnt_nxt   = '0;
      stage_nxt = '0; // RQ1
    end else begin
      case (state_r)
        CRS_POR: begin
          // Hold power-on reset low, then release the first stage
          if (cnt_done(cnt_r, POR_HOLD_CYC)) begin // RQ3
            state_nxt       = CRS_DBNC;
            cnt_nxt         = '0;
            stage_nxt.por_n = 1'b1;
          end else begin
            cnt_nxt = cnt_r + CW'(1);
          end
        end
        CRS_DBNC: begin
          // Debounce span before the source stage lets go
          if (cnt_done(cnt_r, DEBOUNCE_CYC)) begin // RQ4
            state_nxt                = CRS_BOOT;
            cnt_nxt                  = '0;
            stage_nxt.reset_source_n = 1'b1;
          end else begin
            cnt_nxt = cnt_r + CW'(1);
          end
        end
        CRS_BOOT: begin
          // Boot loader leaves reset and starts the copy
          state_nxt                   = CRS_WAIT;
          stage_nxt.boot_loader_rst_n = 1'b1;
          copy_nxt.start              = 1'b1; // RQ6
          copy_nxt.addr               = '0;
        end
        CRS_WAIT: begin
          // Copy must finish and the minimum phase time elapse
          if (cnt_r < CW'(BOOT_CYC)) begin // RQ5
            cnt_nxt = cnt_r + CW'(1);
          end
          if (copy_done && cnt_r >= CW'(BOOT_CYC)) begin // RQ5
            state_nxt              = CRS_RUN;
            stage_nxt.system_rst_n = 1'b1;
          end
        end
        CRS_RUN: begin
          // Parked until a new source assertion
          state_nxt = CRS_RUN;
        end
        default: begin
          // Illegal code: restart with every stage held
          state_nxt = CRS_POR;
          cnt_nxt   = '0;
          stage_nxt = '0;
        end
      endcase
    end
  end

  // Flash reset pulse once per power-on event
  // Edge memory keeps a long power-on level from retriggering the pulse;
  // a new rising edge while a pulse runs does not reload it; the running count just runs out.
  always_comb begin
    pwr_seen_nxt = pwr_seen_r;
    fcnt_nxt     = fcnt_r;
    flash_nxt    = 1'b0;
    if (power_on && !pwr_seen_r) begin
      pwr_seen_nxt = 1'b1;
      fcnt_nxt     = 5'(FLASH_PULSE_CYC);
    end else if (!power_on) begin
      pwr_seen_nxt = 1'b0;
    end
    if (fcnt_r != 5'h00) begin
      fcnt_nxt  = fcnt_r - 5'h01;
      flash_nxt = 1'b1; // RQ2
    end
  end

  // Sequencer registers; reset holds every stage asserted
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_r <= CRS_POR;
      cnt_r   <= '0;
      stage_r <= '0;
      copy_r  <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      stage_r <= stage_nxt;
      copy_r  <= copy_nxt;
    end
  end

  // Flash pulse registers; reset drops any pulse in flight
  always_ff @(posedge core_clk) begin
    if (rst) begin
      flash_r    <= 1'b0;
      fcnt_r     <= 5'h00;
      pwr_seen_r <= 1'b0;
    end else begin
      flash_r    <= flash_nxt;
      fcnt_r     <= fcnt_nxt;
      pwr_seen_r <= pwr_seen_nxt;
    end
  end

  // Outputs come straight from the registers above, so no glitch
  // from the next-state logic can reach the reset tree
  assign stage     = stage_r;
  assign copy      = copy_r;
  assign flash_rst = flash_r;

endmodule // crs_top

// ### tb/crs_monitor.sv
// Checker of stage timing and order for the chip reset sequencer
`timescale 1ns/100ps
module crs_monitor #(
  parameter int unsigned BOOT_CYC = 50
) (
  input wire logic           core_clk,
  input wire logic           rst,
  input wire logic           ext_rst_n,
  input wire logic           power_on,
  input wire logic           software_reboot_request,
  input wire logic           copy_done,
  input crs_pkg::crs_stage_t stage,
  input crs_pkg::crs_copy_t  copy,
  input wire logic           flash_rst
);
  import crs_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // Sixteen cycles of flash reset
  sequence s_flash;
    flash_rst [*8] ##1 flash_rst [*8];
  endsequence
  a_src_reset: assert property ((power_on || software_reboot_request) |=> stage == '0)
    else $error("stage not reset by source");
  a_pin_reset: assert property ($fell(ext_rst_n) |-> ##[1:6] stage == '0)
    else $error("stage not reset by pin");
  a_flash_pulse: assert property ($rose(power_on) |=> ##1 s_flash ##1 !flash_rst)
    else $error("flash pulse length wrong");
  a_por_hold: assert property ($rose(stage.por_n) |-> $past(ext_rst_n, 110))
    else $error("power-on release too early");
  a_dbnc_gap: assert property ($rose(stage.reset_source_n) |->
    $past(stage.por_n, 100) && !$past(stage.por_n, 101))
    else $error("debounce gap wrong");
  a_boot_start: assert property ($rose(stage.reset_source_n) |=>
    $rose(stage.boot_loader_rst_n) && copy.start && copy.addr == '0)
    else $error("boot start wrong");
  a_start_pulse: assert property (copy.start |=> !copy.start)
    else $error("start longer than one cycle");
  a_sys_hold: assert property ($rose(stage.system_rst_n) |->
    $past(stage.boot_loader_rst_n, BOOT_CYC - 1) && $past(copy_done))
    else $error("system released too early");
  a_stage_order: assert property (stage.boot_loader_rst_n |-> stage[3:2] == 2'h3)
    else $error("stage order broken");
endmodule // crs_monitor

bind crs_top crs_monitor #(.BOOT_CYC(BOOT_CYC)) mon (
  .core_clk(core_clk), .rst(rst), .ext_rst_n(ext_rst_n), .power_on(power_on),
  .software_reboot_request(software_reboot_request), .copy_done(copy_done),
  .stage(stage), .copy(copy), .flash_rst(flash_rst));

// ### tb/crs_partner.sv
// Partner model: reset pin, power-on detector and boot copy engine
`timescale 1ns/100ps
module crs_partner (
  input  wire logic       core_clk,
  input  wire logic       pin_lo,
  input  wire logic       pwr,
  input  wire logic       start,
  input  wire logic [7:0] dly,
  output logic            ext_rst_n = 1'b0,
  output logic            power_on = 1'b0,
  output logic            copy_done = 1'b0
);
  logic [7:0] cnt_r = 8'h00;
  // Copy ends dly cycles after start; a new start clears a stale done
  always_ff @(posedge core_clk) begin
    ext_rst_n <= !pin_lo;
    power_on <= pwr;
    cnt_r <= start ? dly : (cnt_r != 8'h00 ? cnt_r - 8'h01 : 8'h00);
    copy_done <= !start && (copy_done || cnt_r == 8'h01);
  end
endmodule // crs_partner

// ### tb/tb_crs_top.sv
// Self-checking bench for the chip reset sequencer
`timescale 1ns/100ps
module tb_crs_top;
  import crs_pkg::*;
  localparam int BC = 50;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic pin_lo = 1'b1;
  logic pwr = 1'b0;
  logic reboot = 1'b0;
  logic [7:0] dly = 8'h01;
  logic ext_rst_n, power_on, copy_done, flash_rst;
  crs_stage_t stage;
  crs_copy_t copy;
  int mismatches = 0;
  int checks = 0;
  int seed = 1209;
  int n;
  crs_partner fm (.core_clk(core_clk), .pin_lo(pin_lo), .pwr(pwr), .start(copy.start),
    .dly(dly), .ext_rst_n(ext_rst_n), .power_on(power_on), .copy_done(copy_done));
  crs_top #(.BOOT_CYC(BC)) uut (.core_clk(core_clk), .rst(rst), .ext_rst_n(ext_rst_n),
    .power_on(power_on), .software_reboot_request(reboot), .copy_done(copy_done),
    .stage(stage), .copy(copy), .flash_rst(flash_rst));
  initial forever #10 core_clk = ~core_clk;
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic in_rng(input int c, input int lo, input int hi);
    return c >= lo && c <= hi;
  endfunction
  // Bounded wait for one stage bit to release
  task automatic wait_bit(input int b, output int c);
    c = 0;
    while (stage[b] !== 1'b1 && c < 9000) begin
      @(posedge core_clk);
      c++;
    end
  endtask
  task automatic run_seq(input logic [7:0] d);
    int c;
    dly <= d;
    pin_lo <= 1'b0;
    wait_bit(3, c);
    check(in_rng(c, POR_HOLD_MIN_NS / 20, POR_HOLD_MAX_NS / 20), 1'b1);
    wait_bit(2, c);
    check(in_rng(c, DEBOUNCE_CYC - 1, DEBOUNCE_CYC + 1), 1'b1);
    wait_bit(1, c);
    wait_bit(0, c);
    check(in_rng(c, BC - 1, BC + d + 4), 1'b1);
    check(stage, 4'hF);
  endtask
  task automatic final_report;
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    pwr <= 1'b1;
    n = 0;
    repeat (30) begin
      @(posedge core_clk);
      n += flash_rst;
    end
    check(n, FLASH_PULSE_CYC);
    check(stage, 4'h0);
    pwr <= 1'b0;
    run_seq(8'h01);
    // Abort from RUN after a random delay, by pin or reboot, then rerun
    for (int i = 0; i < 8; i++) begin
      pin_lo <= 1'b0;
      repeat ((($random(seed)) & 511) + 1) @(posedge core_clk);
      if (i % 2 == 1) reboot <= 1'b1;
      else pin_lo <= 1'b1;
      @(posedge core_clk);
      reboot <= 1'b0;
      repeat (8) @(posedge core_clk);
      check(stage, 4'h0);
      run_seq(8'($random(seed) & 127) + 8'h01);
    end
    final_report;
  end
  // Watchdog on far more cycles than the run needs
  initial begin
    repeat (60000) @(posedge core_clk);
    mismatches++;
    final_report;
  end
endmodule // tb_crs_top
